// *** dv/host_serial_model.sv ***
// host side model: shifts 32-bit words into the device's serial pins
// assumes clk_sys is the bench clock; pins change on its falling edge
`timescale 1ns/1ns
module host_serial_model
   import synth_cal_pkg::*;
(
   // bench clock
   input wire logic clk_sys,
   // serial pins toward the device
   output logic sclk_pin,
   output logic sdata_pin,
   output logic le_pin
);
   // ----------------------------------------------------------------
   // fixed reserved words, only ever sent whole
   // ----------------------------------------------------------------
   localparam word_t FIXED_WORD_A = 32'h102D0428;
   localparam word_t FIXED_WORD_B = 32'h0061300B;
   // idle: serial clock parked low, load enable low
   initial begin
      sclk_pin = 1'b0;
      sdata_pin = 1'b0;
      le_pin = 1'b0;
   end
   // msb first, four clocks per pin level to clear the device's syncs
   task automatic send_word(input word_t w);
      for (int i = 31; i >= 0; i--) begin
         sdata_pin = w[i];
         repeat (4) @(negedge clk_sys);
         sclk_pin = 1'b1;
         repeat (4) @(negedge clk_sys);
         sclk_pin = 1'b0;
      end
      // data no longer held: show the inverse, never the stale bit
      sdata_pin = ~w[0];
      repeat (4) @(negedge clk_sys);
      le_pin = 1'b1;
      repeat (4) @(negedge clk_sys);
      le_pin = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask
endmodule

// *** dv/tb_top.sv ***
// bench for the synthesizer calibration sequencer
// assumes the host model drives the pins; pfd runs at clk_sys over 8
`timescale 1ns/1ns
module tb_top;
   import synth_cal_pkg::*;
   // ----------------------------------------------------------------
   // design signals
   // ----------------------------------------------------------------
   logic clk_sys, reset_n, pfd_clk_pin, sclk_pin, sdata_pin, le_pin;
   logic [15:0] applied_int;
   logic [23:0] applied_primary_fraction;
   logic [13:0] applied_auxiliary_fraction, applied_auxiliary_modulus;
   logic [5:0] main_modulus_bits;
   logic freq_update, counter_reset_active, cal_busy, band_sel_tick;
   logic adc_clk_tick, adc_convert_start, adc_power_on, phase_resync;
   cal_state_t cal_phase, ph_q;
   // bench counters and measured gaps
   int fail_count = 0, comparisons = 0, cyc = 0, run = 0, k;
   int adc_cnt = 0, adc_gap = 0, band_cnt = 0, band_gap = 0, plen[4];
   int n_adc = 0, n_conv = 0, n_fu = 0, n_rs = 0, t_fu = 0, t_rs = 0;
   word_t w;
   // converter divider for the 12.5 MHz bench pfd, rounded up, capped at 255
   localparam int ADC_DIV_RAW = ((12_500_000 / 100_000) - 2 + 3) / 4;
   localparam int ADC_DIV = (ADC_DIV_RAW > 255) ? 255 : ADC_DIV_RAW;
   synth_cal_sequencer synth_cal_sequencer_inst (.clk_sys, .reset_n, .sclk_pin, .sdata_pin,
      .le_pin, .pfd_clk_pin, .applied_int, .applied_primary_fraction, .applied_auxiliary_fraction, .applied_auxiliary_modulus,
      .main_modulus_bits, .freq_update, .counter_reset_active, .cal_busy, .cal_phase,
      .band_sel_tick, .adc_clk_tick, .adc_convert_start, .adc_power_on, .phase_resync);
   host_serial_model host_serial_model_inst (.clk_sys, .sclk_pin, .sdata_pin, .le_pin);
   // clocks: system at 10 ns, pfd toggled every 4 system cycles
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      pfd_clk_pin = 1'b0;
      forever begin
         repeat (4) @(negedge clk_sys);
         pfd_clk_pin = ~pfd_clk_pin;
      end
   end
   // monitor: pulse counts, tick spacing and phase lengths in cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      adc_cnt <= adc_clk_tick ? 1 : adc_cnt + 1;
      band_cnt <= band_sel_tick ? 1 : band_cnt + 1;
      if (adc_clk_tick) adc_gap <= adc_cnt;
      if (band_sel_tick) band_gap <= band_cnt;
      n_adc <= n_adc + int'(adc_clk_tick);
      n_conv <= n_conv + int'(adc_convert_start);
      n_fu <= n_fu + int'(freq_update);
      n_rs <= n_rs + int'(phase_resync);
      if (freq_update) t_fu <= cyc;
      if (phase_resync) t_rs <= cyc;
      ph_q <= cal_phase;
      if (cal_phase !== ph_q) begin
         plen[ph_q] <= run;
         run <= 1;
      end else begin
         run <= run + 1;
      end
   end
   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // n pfd ticks, allowing one period of phase slip plus sync delay
   task automatic in_ticks(input string what, input int v, input int n, input int per);
      check(what, 32'(v >= (n - 1) * per && v <= n * per + 12), 32'h1);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (cal_busy !== 1'b0 && n < 6000) begin
         @(negedge clk_sys);
         n++;
      end
      // the monitor records the last phase length one edge after idle
      repeat (2) @(negedge clk_sys);
      check("cal_done", 32'(n < 6000), 32'h1);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // word builders, reserved fields at their fixed values
   function automatic word_t band_w(input logic [7:0] d, input logic [9:0] t,
                                    input logic [4:0] a, input logic [4:0] s);
      return {d, t, a, s, 4'h9};
   endfunction
   function automatic word_t adc_w(input logic [7:0] d, input logic cv, input logic pw);
      return {8'h00, 2'b11, 8'h00, d, cv, pw, 4'hA};
   endfunction
   function automatic word_t int_w(input logic ac, input logic [15:0] v);
      return {10'h000, ac, 1'b0, v, 4'h0};
   endfunction
   function automatic word_t ctl_w(input logic cr);
      return {27'h0, cr, 4'h4};
   endfunction
   // watchdog: whole run is near 20k cycles
   initial begin
      #1_000_000;
      fail_count++;
      report_and_stop;
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      repeat (20) @(negedge clk_sys);
      check("modulus", 32'(main_modulus_bits), 32'h18);
      check("phase_rst", 32'(cal_phase), 32'h0);
      reset_n = 1'b1;
      @(negedge clk_sys);
      // power-up order: 12 down to 1, wait, then word 0
      host_serial_model_inst.send_word({16'h0005, 12'h041, 4'hC});
      host_serial_model_inst.send_word(host_serial_model_inst.FIXED_WORD_B);
      host_serial_model_inst.send_word(adc_w(8'(ADC_DIV), 1'b1, 1'b1));
      host_serial_model_inst.send_word(band_w(8'h01, 10'h002, 5'h01, 5'h03));
      host_serial_model_inst.send_word(host_serial_model_inst.FIXED_WORD_A);
      for (int s = 7; s >= 3; s--) begin
         host_serial_model_inst.send_word(s == 4 ? ctl_w(1'b0) : 32'(s));
      end
      host_serial_model_inst.send_word({14'h0400, 14'h0600, 4'h2});
      host_serial_model_inst.send_word({4'h0, 24'hC6AA69, 4'h1});
      check("primary_fraction_pend", 32'(applied_primary_fraction), 32'h0);
      check("conv_pulses", 32'(n_conv), 32'h1);
      check("adc_power", 32'(adc_power_on), 32'h1);
      repeat (17 * 8 * ADC_DIV + 8) @(negedge clk_sys);
      check("adc_gap", 32'(adc_gap), 32'(8 * ADC_DIV));
      host_serial_model_inst.send_word(int_w(1'b1, 16'h0044));
      check("int", 32'(applied_int), 32'h44);
      check("primary_fraction", 32'(applied_primary_fraction), 32'hC6AA69);
      check("auxiliary_fraction", 32'(applied_auxiliary_fraction), 32'h400);
      check("auxiliary_modulus", 32'(applied_auxiliary_modulus), 32'h600);
      check("fu_pulses", 32'(n_fu), 32'h1);
      check("cal_busy", 32'(cal_busy), 32'h1);
      wait_idle;
      in_ticks("settle_len", plen[1], 6, 8);
      in_ticks("band_len", plen[2], 11, 128);
      in_ticks("level_len", plen[3], 110, 8);
      check("band_gap", 32'(band_gap), 32'h80);
      check("resync_n", 32'(n_rs), 32'h1);
      in_ticks("resync_at", t_rs - t_fu, 5, 8);
      // unmapped select codes must change nothing
      w = adc_w(8'h09, 1'b1, 1'b0);
      w[3:0] = 4'h8;
      host_serial_model_inst.send_word(w);
      w[3:0] = 4'hB;
      host_serial_model_inst.send_word(w);
      check("adc_keep", 32'(adc_power_on), 32'h1);
      check("conv_keep", 32'(n_conv), 32'h1);
      check("gap_keep", 32'(adc_gap), 32'(8 * ADC_DIV));
      // frequency change order, converter off this time
      host_serial_model_inst.send_word(adc_w(8'(ADC_DIV), 1'b0, 1'b0));
      check("conv_off", 32'(n_conv), 32'h1);
      check("adc_off", 32'(adc_power_on), 32'h0);
      host_serial_model_inst.send_word(ctl_w(1'b1));
      check("cnt_rst", 32'(counter_reset_active), 32'h1);
      k = n_adc;
      host_serial_model_inst.send_word({14'h0400, 14'h0600, 4'h2});
      host_serial_model_inst.send_word({4'h0, 24'h123456, 4'h1});
      host_serial_model_inst.send_word(int_w(1'b0, 16'h0064));
      repeat (100) @(negedge clk_sys);
      check("int_new", 32'(applied_int), 32'h64);
      check("primary_fraction_new", 32'(applied_primary_fraction), 32'h123456);
      check("held_adc", 32'(n_adc - k), 32'h0);
      check("held_rs", 32'(n_rs), 32'h1);
      check("held_cal", 32'(cal_busy), 32'h0);
      host_serial_model_inst.send_word(ctl_w(1'b0));
      check("cnt_run", 32'(counter_reset_active), 32'h0);
      repeat (17 * 8 * ADC_DIV + 8) @(negedge clk_sys);
      check("adc_resume", 32'(n_adc > k), 32'h1);
      host_serial_model_inst.send_word(int_w(1'b1, 16'h0064));
      check("cal_again", 32'(cal_busy), 32'h1);
      wait_idle;
      check("fu_total", 32'(n_fu), 32'h3);
      check("resync_2", 32'(n_rs), 32'h2);
      // target-rate rewrite after a half-rate lock: 4, 2, 1, 0, autocal off
      host_serial_model_inst.send_word(ctl_w(1'b0));
      host_serial_model_inst.send_word({14'h0200, 14'h0300, 4'h2});
      host_serial_model_inst.send_word({4'h0, 24'h654321, 4'h1});
      host_serial_model_inst.send_word(int_w(1'b0, 16'h0022));
      check("fast_int", 32'(applied_int), 32'h22);
      check("fast_auxiliary_modulus", 32'(applied_auxiliary_modulus), 32'h300);
      check("fast_primary_fraction", 32'(applied_primary_fraction), 32'h654321);
      check("fast_nocal", 32'(cal_busy), 32'h0);
      check("fast_fu", 32'(n_fu), 32'h4);
      report_and_stop;
   end
endmodule

// *** hdl/serial_word_if.sv ***
// carrier for a received serial word between receiver and register file
// assumes one clock domain, clk_sys
`timescale 1ns/1ns
interface serial_word_if;
   import synth_cal_pkg::*;
   logic valid; // one-cycle pulse per latched word
   word_t word; // latched word, stable until next
   modport src (output valid, output word);
   modport dst (input valid, input word);
endinterface

// *** hdl/serial_word_receiver.sv ***
// three-wire serial shifter: syncs pins, shifts msb first, latches on load enable
// assumes pins are slow against clk_sys (several clocks per half period)
`timescale 1ns/1ns
module serial_word_receiver
   import synth_cal_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // serial pins
   input wire logic sclk_pin,
   input wire logic sdata_pin,
   input wire logic le_pin,
   // word out
   serial_word_if.src word_port
);
   `include "synth_cal_cfg.svh"
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] meta_reg; // first stage, read by second only
   logic [2:0] sync_reg; // {le, sdata, sclk}
   logic [2:0] prev_reg; // for edge detection
   word_t shift_reg; // word being shifted in
   logic valid_reg;
   word_t word_reg;
   wire sclk_rise = sync_reg[0] & ~prev_reg[0];
   wire le_rise = sync_reg[2] & ~prev_reg[2];
   // two flops before any logic looks at a pin
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= 3'h0;
         sync_reg <= 3'h0;
         prev_reg <= 3'h0;
      end else begin
         meta_reg <= {le_pin, sdata_pin, sclk_pin};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end
   // ----------------------------------------------------------------
   // shifter and latch
   // ----------------------------------------------------------------
   // msb first: each new bit pushes older ones upward
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         shift_reg <= `RESET_WORD;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[30:0], sync_reg[1]};
      end
   end
   // load enable edge hands the whole word over
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         valid_reg <= 1'b0;
         word_reg <= `RESET_WORD;
      end else begin
         valid_reg <= le_rise;
         if (le_rise) begin
            word_reg <= shift_reg;
         end
      end
   end
   assign word_port.valid = valid_reg;
   assign word_port.word = word_reg;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   le_latch_word_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         le_rise |=> valid_reg && word_reg == $past(shift_reg))
      else $error("load enable did not latch the shifted word");
endmodule

// *** hdl/synth_cal_cfg.svh ***
// constants for the calibration and configuration word sequencer
// assumes inclusion by bare name from the design modules
`ifndef SYNTH_CAL_CFG_SVH
`define SYNTH_CAL_CFG_SVH
// ----------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------
`define SEL_INT_WORD 4'h0
`define SEL_PRIMARY_FRACTION_WORD 4'h1
`define SEL_AUXILIARY_FRACTION_WORD 4'h2
`define SEL_CTRL_WORD 4'h4
`define SEL_BAND_TIMING 4'h9
`define SEL_ADC_CONFIG 4'hA
`define SEL_RESYNC 4'hC
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SEL_HI 3
`define BAND_DIV_HI 31
`define BAND_DIV_LO 24
`define TIMEOUT_HI 23
`define TIMEOUT_LO 14
`define WAIT_HI 13
`define WAIT_LO 9
`define SETTLE_HI 8
`define SETTLE_LO 4
`define ADC_DIV_HI 13
`define ADC_DIV_LO 6
`define CONVERT_BIT 5
`define ADC_POWER_BIT 4
`define RESYNC_HI 31
`define RESYNC_LO 16
`define COUNTER_RESET_BIT 4
`define AUTOCAL_BIT 21
`define INT_HI 19
`define INT_LO 4
`define PRIMARY_FRACTION_HI 27
`define PRIMARY_FRACTION_LO 4
`define AUXILIARY_FRACTION_HI 31
`define AUXILIARY_FRACTION_LO 18
`define AUXILIARY_MODULUS_HI 17
`define AUXILIARY_MODULUS_LO 4
// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define RESET_WORD 32'h00000000
`define BAND_PRESCALE 12'h010
`define BAND_CYCLES 24'h00000B
`define ALC_FACTOR 24'h000037
`define MAIN_MODULUS_BITS 6'h18
`endif

// *** hdl/synth_cal_pkg.sv ***
// types shared by the sequencer modules
// assumes the cfg header sits on the include path
package synth_cal_pkg;
   // calibration phases after an autocal word zero
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_SETTLE = 2'b01,
      CAL_BAND = 2'b10,
      CAL_LEVEL = 2'b11
   } cal_state_t;
   typedef logic [31:0] word_t;
endpackage

// *** hdl/synth_cal_sequencer.sv ***
// register file and calibration timers of the synthesizer control block
// assumes serial pins and pfd clock arrive asynchronously to clk_sys
`timescale 1ns/1ns
module synth_cal_sequencer
   import synth_cal_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // serial pins from host
   input wire logic sclk_pin,
   input wire logic sdata_pin,
   input wire logic le_pin,
   // phase detector clock
   input wire logic pfd_clk_pin,
   // applied division
   output logic [15:0] applied_int,
   output logic [23:0] applied_primary_fraction,
   output logic [13:0] applied_auxiliary_fraction,
   output logic [13:0] applied_auxiliary_modulus,
   output logic [5:0] main_modulus_bits,
   output logic freq_update,
   // counter reset
   output logic counter_reset_active,
   // calibration
   output logic cal_busy,
   output cal_state_t cal_phase,
   output logic band_sel_tick,
   // converter
   output logic adc_clk_tick,
   output logic adc_convert_start,
   output logic adc_power_on,
   // phase resync
   output logic phase_resync
);
   `include "synth_cal_cfg.svh"
   // ----------------------------------------------------------------
   // serial receiver
   // ----------------------------------------------------------------
   serial_word_if word_bus ();
   serial_word_receiver u_rx (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .sclk_pin(sclk_pin),
      .sdata_pin(sdata_pin),
      .le_pin(le_pin),
      .word_port(word_bus.src)
   );
   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   wire [3:0] sel = word_bus.word[`SEL_HI:0];
   wire wr_int = word_bus.valid && (sel == `SEL_INT_WORD);
   wire wr_primary_fraction = word_bus.valid && (sel == `SEL_PRIMARY_FRACTION_WORD);
   wire wr_auxiliary_fraction = word_bus.valid && (sel == `SEL_AUXILIARY_FRACTION_WORD);
   wire wr_ctrl = word_bus.valid && (sel == `SEL_CTRL_WORD);
   wire wr_band = word_bus.valid && (sel == `SEL_BAND_TIMING);
   wire wr_adc = word_bus.valid && (sel == `SEL_ADC_CONFIG);
   wire wr_resync = word_bus.valid && (sel == `SEL_RESYNC);
   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   word_t band_select_timing_reg; // division, timeout, wait, settle
   word_t adc_configuration_reg; // divider, convert, power
   word_t phase_resync_timeout_reg; // resync count
   word_t primary_fraction_pend_reg; // held until word zero
   word_t auxiliary_fraction_pend_reg; // held until word zero
   logic counter_reset_reg;
   // store the selected word; reserved words 8 and 11 need no storage
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         band_select_timing_reg <= `RESET_WORD;
         adc_configuration_reg <= `RESET_WORD;
         phase_resync_timeout_reg <= `RESET_WORD;
         primary_fraction_pend_reg <= `RESET_WORD;
         auxiliary_fraction_pend_reg <= `RESET_WORD;
         counter_reset_reg <= 1'b0;
      end else begin
         if (wr_band) band_select_timing_reg <= word_bus.word;
         if (wr_adc) adc_configuration_reg <= word_bus.word;
         if (wr_resync) phase_resync_timeout_reg <= word_bus.word;
         if (wr_primary_fraction) primary_fraction_pend_reg <= word_bus.word;
         if (wr_auxiliary_fraction) auxiliary_fraction_pend_reg <= word_bus.word;
         if (wr_ctrl) counter_reset_reg <= word_bus.word[`COUNTER_RESET_BIT];
      end
   end
   // ----------------------------------------------------------------
   // field views
   // ----------------------------------------------------------------
   wire [7:0] band_div = band_select_timing_reg[`BAND_DIV_HI:`BAND_DIV_LO];
   wire [9:0] cal_timeout = band_select_timing_reg[`TIMEOUT_HI:`TIMEOUT_LO];
   wire [4:0] level_wait = band_select_timing_reg[`WAIT_HI:`WAIT_LO];
   wire [4:0] settle_cnt = band_select_timing_reg[`SETTLE_HI:`SETTLE_LO];
   wire [7:0] adc_div = adc_configuration_reg[`ADC_DIV_HI:`ADC_DIV_LO];
   wire [15:0] resync_count = phase_resync_timeout_reg[`RESYNC_HI:`RESYNC_LO];
   // timeout is the common multiplier of the settle and level timers; the band phase uses band_div and BAND_CYCLES
   wire [23:0] settle_len = 24'(cal_timeout) * 24'(settle_cnt);
   wire [23:0] level_len = 24'(cal_timeout) * 24'(level_wait) * `ALC_FACTOR;
   wire [11:0] band_len = 12'(band_div) * `BAND_PRESCALE;
   // ----------------------------------------------------------------
   // applied frequency words
   // ----------------------------------------------------------------
   // word zero commits the pending fractions together with the integer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         applied_int <= 16'h0000;
         applied_primary_fraction <= 24'h000000;
         applied_auxiliary_fraction <= 14'h0000;
         applied_auxiliary_modulus <= 14'h0000;
         freq_update <= 1'b0;
      end else begin
         freq_update <= wr_int;
         if (wr_int) begin
            applied_int <= word_bus.word[`INT_HI:`INT_LO];
            applied_primary_fraction <= primary_fraction_pend_reg[`PRIMARY_FRACTION_HI:`PRIMARY_FRACTION_LO];
            applied_auxiliary_fraction <= auxiliary_fraction_pend_reg[`AUXILIARY_FRACTION_HI:`AUXILIARY_FRACTION_LO];
            applied_auxiliary_modulus <= auxiliary_fraction_pend_reg[`AUXILIARY_MODULUS_HI:`AUXILIARY_MODULUS_LO];
         end
      end
   end
   // fraction is taken over a fixed 2^24 modulus
   assign main_modulus_bits = `MAIN_MODULUS_BITS;
   assign counter_reset_active = counter_reset_reg;
   // ----------------------------------------------------------------
   // pfd clock sampling
   // ----------------------------------------------------------------
   logic pfd_meta_reg; // first stage, read by second only
   logic pfd_sync_reg;
   logic pfd_prev_reg;
   wire pfd_tick = pfd_sync_reg & ~pfd_prev_reg;
   // limits pfd to well under half of clk_sys
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pfd_meta_reg <= 1'b0;
         pfd_sync_reg <= 1'b0;
         pfd_prev_reg <= 1'b0;
      end else begin
         pfd_meta_reg <= pfd_clk_pin;
         pfd_sync_reg <= pfd_meta_reg;
         pfd_prev_reg <= pfd_sync_reg;
      end
   end
   // ----------------------------------------------------------------
   // band-select and converter clock dividers
   // ----------------------------------------------------------------
   logic [11:0] band_cnt_reg;
   logic [7:0] adc_cnt_reg;
   wire band_wrap = pfd_tick && (band_cnt_reg + 12'h001 >= band_len);
   wire adc_wrap = pfd_tick && (adc_cnt_reg + 8'h01 >= adc_div);
   // counter reset holds the band divider; the converter divider runs
   // off the reference counter output, so it is held too
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         band_cnt_reg <= 12'h000;
         adc_cnt_reg <= 8'h00;
         band_sel_tick <= 1'b0;
         adc_clk_tick <= 1'b0;
      end else if (counter_reset_reg) begin
         band_cnt_reg <= 12'h000;
         adc_cnt_reg <= 8'h00;
         band_sel_tick <= 1'b0;
         adc_clk_tick <= 1'b0;
      end else begin
         band_cnt_reg <= band_wrap ? 12'h000 : band_cnt_reg + 12'(pfd_tick);
         adc_cnt_reg <= adc_wrap ? 8'h00 : adc_cnt_reg + 8'(pfd_tick);
         band_sel_tick <= band_wrap;
         adc_clk_tick <= adc_wrap;
      end
   end
   // ----------------------------------------------------------------
   // converter control
   // ----------------------------------------------------------------
   // a write with the convert bit set starts one conversion
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         adc_convert_start <= 1'b0;
      end else begin
         adc_convert_start <= wr_adc && word_bus.word[`CONVERT_BIT];
      end
   end
   assign adc_power_on = adc_configuration_reg[`ADC_POWER_BIT];
   // ----------------------------------------------------------------
   // calibration sequence
   // ----------------------------------------------------------------
   cal_state_t cal_state_reg;
   cal_state_t cal_state_next;
   logic [23:0] cal_cnt_reg;
   wire cal_start = wr_int && word_bus.word[`AUTOCAL_BIT] && !counter_reset_reg;
   wire phase_tick = (cal_state_reg == CAL_BAND) ? band_wrap : pfd_tick;
   logic [23:0] phase_len;
   always_comb begin
      phase_len = settle_len;
      cal_state_next = cal_state_reg;
      case (cal_state_reg)
         CAL_SETTLE: begin
            phase_len = settle_len;
            cal_state_next = CAL_BAND;
         end
         CAL_BAND: begin
            phase_len = `BAND_CYCLES;
            cal_state_next = CAL_LEVEL;
         end
         CAL_LEVEL: begin
            phase_len = level_len;
            cal_state_next = CAL_IDLE;
         end
         default: begin
            phase_len = settle_len;
            cal_state_next = CAL_IDLE;
         end
      endcase
   end
   wire phase_done = phase_tick && (cal_cnt_reg + 24'h000001 >= phase_len);
   // counter reset forces band select back to idle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cal_state_reg <= CAL_IDLE;
         cal_cnt_reg <= 24'h000000;
      end else if (counter_reset_reg) begin
         cal_state_reg <= CAL_IDLE;
         cal_cnt_reg <= 24'h000000;
      end else if (cal_start) begin
         cal_state_reg <= CAL_SETTLE;
         cal_cnt_reg <= 24'h000000;
      end else if (cal_state_reg != CAL_IDLE) begin
         cal_state_reg <= phase_done ? cal_state_next : cal_state_reg;
         cal_cnt_reg <= phase_done ? 24'h000000 : cal_cnt_reg + 24'(phase_tick);
      end
   end
   assign cal_phase = cal_state_reg;
   assign cal_busy = (cal_state_reg != CAL_IDLE);
   // ----------------------------------------------------------------
   // phase resync timer
   // ----------------------------------------------------------------
   logic [15:0] resync_cnt_reg;
   logic resync_run_reg;
   // armed by word zero outside counter reset, fires after the programmed pfd cycles
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         resync_cnt_reg <= 16'h0000;
         resync_run_reg <= 1'b0;
         phase_resync <= 1'b0;
      end else if (counter_reset_reg) begin
         resync_run_reg <= 1'b0;
         phase_resync <= 1'b0;
      end else if (wr_int) begin
         resync_cnt_reg <= resync_count;
         resync_run_reg <= 1'b1;
         phase_resync <= 1'b0;
      end else begin
         phase_resync <= resync_run_reg && pfd_tick && (resync_cnt_reg <= 16'h0001);
         if (resync_run_reg && pfd_tick) begin
            resync_cnt_reg <= resync_cnt_reg - 16'(resync_cnt_reg != 16'h0000);
            resync_run_reg <= (resync_cnt_reg > 16'h0001);
         end
      end
   end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   band_word_store_a:
      assert property (wr_band |=> band_select_timing_reg == $past(word_bus.word))
      else $error("band timing word not stored");
   adc_word_store_a:
      assert property (wr_adc |=> adc_power_on == $past(word_bus.word[`ADC_POWER_BIT]))
      else $error("converter word not stored");
   resync_word_store_a:
      assert property (wr_resync |=> phase_resync_timeout_reg == $past(word_bus.word))
      else $error("resync word not stored");
   convert_on_write_a:
      assert property (wr_adc && word_bus.word[`CONVERT_BIT] |=> adc_convert_start)
      else $error("conversion not started on write");
   frac_pending_a:
      assert property (!wr_int |=> $stable(applied_primary_fraction) && $stable(applied_auxiliary_modulus))
      else $error("fraction applied without word zero");
   counter_reset_hold_a:
      assert property (counter_reset_reg |=> !cal_busy && !band_sel_tick && !adc_clk_tick)
      else $error("counters ran during counter reset");
   cal_start_settle_a:
      assert property (cal_start |=> cal_phase == CAL_SETTLE)
      else $error("calibration did not start in settle phase");
   resync_fire_a:
      assert property (phase_resync |-> $past(resync_run_reg) && $past(pfd_tick))
      else $error("resync fired without a pfd cycle");
   band_div_tick_a:
      assert property (band_sel_tick |-> $past(pfd_tick) && !$past(counter_reset_reg))
      else $error("band tick without pfd edge");
   cal_full_run_c: cover property (cal_phase == CAL_LEVEL ##1 cal_phase == CAL_IDLE);
   resync_seen_c: cover property (freq_update ##[1:1000] phase_resync);
   convert_seen_c: cover property (adc_convert_start);
endmodule
